/* core/admc_pkg.sv */
// Shared constants, register map and carrier types of the monitor control.
package admc_pkg;

  // ==========================================================================
  // Register map (word index on the plain register port).
  localparam logic [7:0] ADMC_OFS_CTRL = 8'h00;
  localparam logic [7:0] ADMC_OFS_AUX_MUX = 8'h01;
  localparam logic [7:0] ADMC_OFS_GPIO = 8'h02;
  localparam logic [7:0] ADMC_OFS_DIAG = 8'h03;
  localparam logic [7:0] ADMC_OFS_CH_DIAG_EN = 8'h04;
  localparam logic [7:0] ADMC_OFS_CH_REF_MON = 8'h05;
  localparam logic [7:0] ADMC_OFS_AUX_RESULT = 8'h06;
  localparam logic [7:0] ADMC_OFS_STATUS = 8'h07;

  // ==========================================================================
  // Field positions and reset values.
  localparam int ADMC_CTRL_READOUT_BIT = 0;
  localparam int ADMC_CTRL_FILT_LSB = 1;
  localparam int ADMC_DIAG_REF_LSB = 4;
  localparam int ADMC_ST_BUSY_BIT = 0;
  localparam int ADMC_ST_UNREAD_BIT = 1;
  localparam int ADMC_ST_PINMODE_BIT = 2;
  localparam int ADMC_ST_OVERRUN_BIT = 3;
  localparam logic [1:0] ADMC_FILT_RST = 2'h2;
  localparam logic [1:0] ADMC_FILT_DIRECT = 2'h3;
  localparam logic [4:0] ADMC_AUX_MUX_MAX = 5'h15;
  localparam logic [3:0] ADMC_DIAG_CODE_MAX = 4'h9;
  localparam logic [3:0] ADMC_DIAG_CODE_STIM = 4'h2;
  // Monitor inputs that pass the divide-by-six attenuator, one bit a code.
  localparam logic [21:0] ADMC_ATTEN_MAP = 22'h27BFC0;

  // ==========================================================================
  // Timing.
  localparam int ADMC_CLK_PERIOD_PS = 8000;
  localparam int ADMC_START_MAX_RATE_HZ = 256000;
  // Worked out from the rate in kHz so every step stays within 32 bits.
  localparam int ADMC_START_MIN_PERIOD_PS =
    1000000000 / (ADMC_START_MAX_RATE_HZ / 1000);
  localparam int ADMC_START_MIN_CYCLES =
    (ADMC_START_MIN_PERIOD_PS + ADMC_CLK_PERIOD_PS - 1) / ADMC_CLK_PERIOD_PS;
  localparam int ADMC_FILT_HALF_CYCLES = 3;
  localparam int ADMC_FILT_CYCLES = (ADMC_FILT_HALF_CYCLES + 1) / 2;
  localparam int ADMC_ACQ_CYCLES = 16;
  localparam int ADMC_RES_BITS = 12;
  localparam int ADMC_FRAME_BITS = 16;
  localparam int ADMC_PAD_BITS = ADMC_FRAME_BITS - ADMC_RES_BITS;
  localparam logic [4:0] ADMC_CAPTURE_BIT = 5'h02;

  // ==========================================================================
  // Carrier types.
  typedef struct packed {
    logic [3:0] code;
    logic [1:0] ref_sel;
  } admc_diag_cfg_t;

  typedef struct packed {
    logic [4:0] sel;
    logic atten;
  } admc_aux_mux_t;

  typedef enum {ADMC_IDLE, ADMC_ACQ, ADMC_CONV} admc_sar_state_t;

endpackage : admc_pkg

/* core/admc_top.sv */
// Auxiliary monitor converter and diagnostic input multiplexer control.
// ============================================================================
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
module admc_top
  import admc_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int ACQ_CYCLES = ADMC_ACQ_CYCLES
)
(
  // Clock and reset.
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  // Register port.
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [15:0] I_REG_WDATA,
  input wire logic I_REG_WRITE,
  input wire logic I_REG_READ,
  output logic [15:0] O_REG_RDATA,
  // Device pins.
  input wire logic I_PIN_CTRL_MODE,
  input wire logic I_AUX_CONVERT_START_PIN,
  output logic [2:0] O_GPIO,
  // Converter core.
  input wire logic I_SAR_CMP,
  output logic [ADMC_RES_BITS-1:0] O_SAR_DAC,
  output logic O_SAR_SAMPLE,
  output logic O_SAR_BUSY,
  output admc_aux_mux_t O_AUX_MUX,
  // Diagnostic multiplexer of the sigma-delta channels.
  output admc_diag_cfg_t O_DIAG_CFG,
  output logic O_DIAG_FLOAT,
  output logic O_DIAG_STIM_280MV,
  output logic [CHANNELS-1:0] O_CH_INPUT_FROM_DIAG,
  output logic [CHANNELS-1:0] O_CH_REF_SUPPLY,
  // Serial link, on its own clock.
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic [ADMC_FRAME_BITS-1:0] I_SPI_REG_WORD,
  output logic O_SDO,
  output logic O_SDO_OE
);

  // ==========================================================================
  // Declarations.
  logic [1:0] mode_sync_ff;
  logic [1:0] start_sync_ff;
  logic pin_mode;
  logic readout_ff;
  logic [1:0] filt_ff;
  logic [4:0] aux_sel_ff;
  logic [2:0] gpio_ff;
  logic [3:0] diag_code_ff;
  logic [1:0] diag_ref_ff;
  logic [CHANNELS-1:0] ch_diag_en_ff;
  logic [CHANNELS-1:0] ch_ref_mon_ff;
  logic [ADMC_RES_BITS-1:0] result_ff;
  logic unread_ff;
  logic overrun_ff;
  logic [15:0] rdata_ff;
  logic [1:0] filt_cnt_ff;
  logic filt_level_ff;
  logic level_q_ff;
  logic start_level;
  logic start_rise;
  logic [9:0] space_cnt_ff;
  logic start_take;
  admc_sar_state_t state_ff;
  admc_sar_state_t nxt_state;
  logic [7:0] acq_cnt_ff;
  logic [ADMC_RES_BITS-1:0] dac_ff;
  logic [ADMC_RES_BITS-1:0] mask_ff;
  logic [ADMC_RES_BITS-1:0] trial_code;
  logic conv_done;
  logic pub_tgl_ff;
  logic [1:0] ack_sync_ff;
  logic ack_seen_ff;
  logic ack_event;
  logic bus_result_read;
  logic wr_hit;
  // Link domain.
  logic [1:0] pub_sync_ff;
  logic cap_tgl_ff;
  logic [ADMC_RES_BITS-1:0] cap_word_ff;
  logic [4:0] bit_cnt_ff;
  logic [1:0] ro_sync_ff;
  logic ro_core_ff;
  logic [ADMC_FRAME_BITS-1:0] aux_frame;
  logic [3:0] bit_idx;

  // ==========================================================================
  // Pin synchronisers. The first stage feeds only the second.
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      mode_sync_ff <= 2'h0;
      start_sync_ff <= 2'h0;
    end
    else
    begin
      mode_sync_ff <= {mode_sync_ff[0], I_PIN_CTRL_MODE};
      start_sync_ff <= {start_sync_ff[0], I_AUX_CONVERT_START_PIN};
    end
  end

  assign pin_mode = mode_sync_ff[1];

  // ==========================================================================
  // Register writes. Out-of-range selector codes are dropped so the analog
  // multiplexers never see an undefined code.
  assign wr_hit = I_REG_WRITE;

  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      readout_ff <= 1'b0;
      filt_ff <= ADMC_FILT_RST;
    end
    else if (wr_hit && I_REG_ADDR == ADMC_OFS_CTRL)
    begin
      readout_ff <= I_REG_WDATA[ADMC_CTRL_READOUT_BIT];
      filt_ff <= I_REG_WDATA[ADMC_CTRL_FILT_LSB +: 2];
    end
  end

  // Monitor multiplexer selector.
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      aux_sel_ff <= 5'h00;
    else if (wr_hit && I_REG_ADDR == ADMC_OFS_AUX_MUX &&
             I_REG_WDATA[4:0] <= ADMC_AUX_MUX_MAX)
      aux_sel_ff <= I_REG_WDATA[4:0];
  end

  // General outputs for the external dual multiplexer.
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      gpio_ff <= 3'h0;
    else if (wr_hit && I_REG_ADDR == ADMC_OFS_GPIO)
      gpio_ff <= I_REG_WDATA[2:0];
  end

  // Shared diagnostic multiplexer setting, one for all channels.
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      diag_code_ff <= 4'h0;
      diag_ref_ff <= 2'h0;
    end
    else if (wr_hit && I_REG_ADDR == ADMC_OFS_DIAG)
    begin
      if (I_REG_WDATA[3:0] <= ADMC_DIAG_CODE_MAX)
        diag_code_ff <= I_REG_WDATA[3:0];
      diag_ref_ff <= I_REG_WDATA[ADMC_DIAG_REF_LSB +: 2];
    end
  end

  // Per-channel diagnostic enable and supply monitor bits.
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      ch_diag_en_ff <= '0;
      ch_ref_mon_ff <= '0;
    end
    else if (wr_hit)
    begin
      if (I_REG_ADDR == ADMC_OFS_CH_DIAG_EN)
        ch_diag_en_ff <= I_REG_WDATA[CHANNELS-1:0];
      if (I_REG_ADDR == ADMC_OFS_CH_REF_MON)
        ch_ref_mon_ff <= I_REG_WDATA[CHANNELS-1:0];
    end
  end

  // ==========================================================================
  // Register reads, data in the cycle after the strobe. Unmapped reads zero.
  assign bus_result_read = I_REG_READ && I_REG_ADDR == ADMC_OFS_AUX_RESULT;

  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      rdata_ff <= 16'h0000;
    else if (I_REG_READ)
    begin
      case (I_REG_ADDR)
        ADMC_OFS_CTRL: rdata_ff <= {13'h0000, filt_ff, readout_ff};
        ADMC_OFS_AUX_MUX: rdata_ff <= {11'h000, aux_sel_ff};
        ADMC_OFS_GPIO: rdata_ff <= {13'h0000, gpio_ff};
        ADMC_OFS_DIAG: rdata_ff <= {10'h000, diag_ref_ff, diag_code_ff};
        ADMC_OFS_CH_DIAG_EN: rdata_ff <= 16'(ch_diag_en_ff);
        ADMC_OFS_CH_REF_MON: rdata_ff <= 16'(ch_ref_mon_ff);
        ADMC_OFS_AUX_RESULT: rdata_ff <= {4'h0, result_ff};
        ADMC_OFS_STATUS: rdata_ff <= {12'h000, overrun_ff, pin_mode,
                                      unread_ff, state_ff != ADMC_IDLE};
        default: rdata_ff <= 16'h0000;
      endcase
    end
    else
      rdata_ff <= 16'h0000;
  end

  assign O_REG_RDATA = rdata_ff;

  // ==========================================================================
  // Start filter. Sampling on the clock, 1.5 cycles rounds up to two samples
  // high in a row; a shorter glitch never reaches the converter.
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      filt_cnt_ff <= 2'h0;
      filt_level_ff <= 1'b0;
    end
    else if (!start_sync_ff[1])
    begin
      filt_cnt_ff <= 2'h0;
      filt_level_ff <= 1'b0;
    end
    else if (filt_cnt_ff < 2'(ADMC_FILT_CYCLES - 1))
      filt_cnt_ff <= filt_cnt_ff + 2'h1;
    else
      filt_level_ff <= 1'b1;
  end

  // Field 11 bypasses the filter; every other value keeps it in.
  assign start_level = (filt_ff == ADMC_FILT_DIRECT) ? start_sync_ff[1]
                                                      : filt_level_ff;

  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      level_q_ff <= 1'b0;
    else
      level_q_ff <= start_level;
  end

  assign start_rise = start_level && !level_q_ff;

  // Spacing guard: a start sooner than the fastest legal rate, or during a
  // conversion, is refused and flagged rather than corrupting the sequence.
  assign start_take = start_rise && !pin_mode && state_ff == ADMC_IDLE &&
                      space_cnt_ff == 10'h000;

  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      space_cnt_ff <= 10'h000;
    else if (start_take)
      space_cnt_ff <= 10'(ADMC_START_MIN_CYCLES - 1);
    else if (space_cnt_ff != 10'h000)
      space_cnt_ff <= space_cnt_ff - 10'h001;
  end

  // ==========================================================================
  // Successive approximation sequencer, one result bit a cycle.
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ADMC_IDLE: if (start_take) nxt_state = ADMC_ACQ;
      ADMC_ACQ: if (acq_cnt_ff == 8'(ACQ_CYCLES - 1)) nxt_state = ADMC_CONV;
      ADMC_CONV: if (mask_ff[0]) nxt_state = ADMC_IDLE;
      default: nxt_state = ADMC_IDLE;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      state_ff <= ADMC_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Acquisition counter.
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      acq_cnt_ff <= 8'h00;
    else if (state_ff == ADMC_ACQ)
      acq_cnt_ff <= acq_cnt_ff + 8'h01;
    else
      acq_cnt_ff <= 8'h00;
  end

  // A high comparator keeps the trial bit.
  assign trial_code = I_SAR_CMP ? dac_ff : (dac_ff & ~mask_ff);
  assign conv_done = state_ff == ADMC_CONV && mask_ff[0];

  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      dac_ff <= '0;
      mask_ff <= '0;
    end
    else if (state_ff == ADMC_ACQ)
    begin
      dac_ff <= {1'b1, {(ADMC_RES_BITS-1){1'b0}}};
      mask_ff <= {1'b1, {(ADMC_RES_BITS-1){1'b0}}};
    end
    else if (state_ff == ADMC_CONV)
    begin
      dac_ff <= trial_code | (mask_ff >> 1);
      mask_ff <= mask_ff >> 1;
    end
  end

  // Result is held until a later completion replaces it.
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      result_ff <= '0;
      pub_tgl_ff <= 1'b0;
    end
    else if (conv_done)
    begin
      result_ff <= trial_code;
      pub_tgl_ff <= ~pub_tgl_ff;
    end
  end

  // Acknowledge from the link domain, back through two flops.
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      ack_sync_ff <= 2'h0;
      ack_seen_ff <= 1'b0;
    end
    else
    begin
      ack_sync_ff <= {ack_sync_ff[0], cap_tgl_ff};
      ack_seen_ff <= ack_sync_ff[1];
    end
  end

  assign ack_event = ack_sync_ff[1] != ack_seen_ff;

  // Unread and overrun flags; a new event wins over a clear in one cycle.
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      unread_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end
    else
    begin
      if (conv_done)
        unread_ff <= 1'b1;
      else if (ack_event || bus_result_read)
        unread_ff <= 1'b0;
      if (start_rise && !pin_mode && !start_take)
        overrun_ff <= 1'b1;
      else if (wr_hit && I_REG_ADDR == ADMC_OFS_STATUS &&
               I_REG_WDATA[ADMC_ST_OVERRUN_BIT])
        overrun_ff <= 1'b0;
    end
  end

  // Gated readout select from one flop, so the crossing never samples a
  // glitch of the gating when both inputs change on one edge.
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      ro_core_ff <= 1'b0;
    else
      ro_core_ff <= readout_ff && !pin_mode;
  end

  // ==========================================================================
  // Outputs toward the analog side. Pin mode parks the general outputs at zero.
  assign O_SAR_DAC = dac_ff;
  assign O_SAR_SAMPLE = state_ff == ADMC_ACQ;
  assign O_SAR_BUSY = state_ff != ADMC_IDLE;
  assign O_AUX_MUX.sel = aux_sel_ff;
  assign O_AUX_MUX.atten = ADMC_ATTEN_MAP[aux_sel_ff];
  assign O_GPIO = pin_mode ? 3'h0 : gpio_ff;
  assign O_DIAG_CFG.code = diag_code_ff;
  assign O_DIAG_CFG.ref_sel = diag_ref_ff;
  assign O_DIAG_FLOAT = diag_code_ff < ADMC_DIAG_CODE_STIM;
  assign O_DIAG_STIM_280MV = diag_code_ff == ADMC_DIAG_CODE_STIM;
  assign O_CH_INPUT_FROM_DIAG = ch_diag_en_ff | ch_ref_mon_ff;
  assign O_CH_REF_SUPPLY = ch_ref_mon_ff;

  // ==========================================================================
  // Link domain. The serial clock stops between frames, so the bit counter
  // is cleared by the frame's own select and the result crosses by toggle.
  always_ff @(posedge I_SCLK or posedge I_CS_N)
  begin
    if (I_CS_N)
      bit_cnt_ff <= 5'h00;
    else if (bit_cnt_ff != 5'(ADMC_FRAME_BITS))
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
  end

  // Crossing stages; the first ones feed only the second ones.
  always_ff @(posedge I_SCLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      pub_sync_ff <= 2'h0;
      ro_sync_ff <= 2'h0;
    end
    else
    begin
      pub_sync_ff <= {pub_sync_ff[0], pub_tgl_ff};
      ro_sync_ff <= {ro_sync_ff[0], ro_core_ff};
    end
  end

  // Capture a fresh result while the pad bits go out; the core word has
  // been stable since its toggle, so taking it whole is safe.
  always_ff @(posedge I_SCLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      cap_tgl_ff <= 1'b0;
      cap_word_ff <= '0;
    end
    else if (bit_cnt_ff == ADMC_CAPTURE_BIT && pub_sync_ff[1] != cap_tgl_ff)
    begin
      cap_tgl_ff <= pub_sync_ff[1];
      cap_word_ff <= result_ff;
    end
  end

  assign aux_frame = {{ADMC_PAD_BITS{1'b0}}, cap_word_ff};
  assign bit_idx = 4'(ADMC_FRAME_BITS - 1) - bit_cnt_ff[3:0];

  // With the gated readout select set, the low 12 bits of the frame come from the result word; the top four are zero pad.
  assign O_SDO = I_CS_N ? 1'b0 :
                 ro_sync_ff[1] ? aux_frame[bit_idx]
                               : I_SPI_REG_WORD[bit_idx];
  assign O_SDO_OE = !I_CS_N;

endmodule : admc_top

/* tb/admc_top_sva.sv */
// Port assertions of the monitor converter control.
`timescale 1ns/1ns
module admc_top_sva
  import admc_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int ACQ_CYCLES = ADMC_ACQ_CYCLES
)
(
  // Clock and reset.
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  // Watched pins and outputs.
  input wire logic I_PIN_CTRL_MODE,
  input wire logic [2:0] O_GPIO,
  input wire logic [ADMC_RES_BITS-1:0] O_SAR_DAC,
  input wire logic O_SAR_SAMPLE,
  input wire logic O_SAR_BUSY,
  input wire admc_aux_mux_t O_AUX_MUX,
  input wire admc_diag_cfg_t O_DIAG_CFG,
  input wire logic O_DIAG_FLOAT,
  input wire logic O_DIAG_STIM_280MV,
  input wire logic [CHANNELS-1:0] O_CH_INPUT_FROM_DIAG,
  input wire logic [CHANNELS-1:0] O_CH_REF_SUPPLY
);
  // ====================
  // Helpers.
  // Codes 6-13, 15-18 and 21 pass the divide-by-six path.
  localparam logic [21:0] ATTEN = 22'h27BFC0;
  int acq_cnt_ff;
  // Counts the acquisition cycles, so the window length is checked exactly.
  always_ff @(posedge I_CLOCK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      acq_cnt_ff <= 0;
    else if (O_SAR_SAMPLE)
      acq_cnt_ff <= acq_cnt_ff + 1;
    else
      acq_cnt_ff <= 0;
  end
  default clocking dcb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RESET_N);
  // ====================
  // Assertions.
  a_atten_map: assert property (O_AUX_MUX.sel <= 5'h15 &&
    O_AUX_MUX.atten == ATTEN[O_AUX_MUX.sel])
    else $error("monitor attenuation flag wrong");
  a_diag_float: assert property (O_DIAG_CFG.code <= 4'h9 &&
    O_DIAG_FLOAT == (O_DIAG_CFG.code < 4'h2))
    else $error("diag float flag wrong");
  a_diag_stim: assert property (
    O_DIAG_STIM_280MV == (O_DIAG_CFG.code == 4'h2))
    else $error("diag stimulus flag wrong");
  a_ref_monitor: assert property (
    (O_CH_REF_SUPPLY & ~O_CH_INPUT_FROM_DIAG) == '0)
    else $error("supply reference without diag input");
  a_pin_gpio: assert property (
    I_PIN_CTRL_MODE [*4] |-> O_GPIO == 3'h0)
    else $error("general outputs driven in pin mode");
  a_pin_nostart: assert property (
    I_PIN_CTRL_MODE [*4] ##0 !O_SAR_BUSY |=> !O_SAR_BUSY)
    else $error("conversion started in pin mode");
  a_acq_length: assert property (
    $fell(O_SAR_SAMPLE) |-> acq_cnt_ff == ACQ_CYCLES)
    else $error("acquisition window length wrong");
  a_conv_length: assert property ($fell(O_SAR_SAMPLE) |->
    (O_SAR_BUSY && O_SAR_DAC == 12'h800) ##1 O_SAR_BUSY [*8]
    ##1 O_SAR_BUSY [*3] ##1 !O_SAR_BUSY)
    else $error("conversion length wrong");
  a_busy_start: assert property (
    $rose(O_SAR_BUSY) |-> O_SAR_SAMPLE)
    else $error("busy without acquisition");
  // Main scenarios reached.
  c_conv: cover property ($fell(O_SAR_SAMPLE));
  c_stim: cover property (O_DIAG_STIM_280MV);
  c_atten: cover property (O_AUX_MUX.atten);
  c_pin: cover property (I_PIN_CTRL_MODE [*4]);
endmodule : admc_top_sva

bind admc_top admc_top_sva #(
  .CHANNELS(CHANNELS),
  .ACQ_CYCLES(ACQ_CYCLES)
) u_sva (
  .I_CLOCK(I_CLOCK),
  .I_RESET_N(I_RESET_N),
  .I_PIN_CTRL_MODE(I_PIN_CTRL_MODE),
  .O_GPIO(O_GPIO),
  .O_SAR_DAC(O_SAR_DAC),
  .O_SAR_SAMPLE(O_SAR_SAMPLE),
  .O_SAR_BUSY(O_SAR_BUSY),
  .O_AUX_MUX(O_AUX_MUX),
  .O_DIAG_CFG(O_DIAG_CFG),
  .O_DIAG_FLOAT(O_DIAG_FLOAT),
  .O_DIAG_STIM_280MV(O_DIAG_STIM_280MV),
  .O_CH_INPUT_FROM_DIAG(O_CH_INPUT_FROM_DIAG),
  .O_CH_REF_SUPPLY(O_CH_REF_SUPPLY)
);

/* tb/admc_spi_host.sv */
// Behavioural serial host that reads one 16-bit frame per request.
`timescale 1ns/1ns
module admc_spi_host
(
  // Frame request.
  input wire logic i_go,
  // Link pins.
  input wire logic i_sdo,
  output logic o_sclk,
  output logic o_cs_n,
  // Captured word.
  output logic [15:0] o_word,
  output logic o_done
);
  // ====================
  // Frame engine.
  // The clock stands low between frames, as a real host leaves it.
  initial
  begin
    o_sclk = 1'b0;
    // A late update gives the frame counter its clearing edge at start.
    o_cs_n <= 1'b1;
    o_word = 16'h0000;
    o_done = 1'b0;
  end
  // Sample before each rising edge, MSB first, 125 ns per bit.
  always @(posedge i_go)
  begin
    o_done = 1'b0;
    o_cs_n = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      #62;
      o_word = {o_word[14:0], i_sdo};
      o_sclk = 1'b1;
      #63;
      o_sclk = 1'b0;
    end
    #62;
    o_cs_n = 1'b1;
    o_done = 1'b1;
  end
endmodule : admc_spi_host

/* tb/aux_adc_diag_mux_control_test.sv */
// Self-checking bench of the monitor converter control.
`timescale 1ns/1ns
module aux_adc_diag_mux_control_test;
  import admc_pkg::*;
  // ====================
  // Signals.
  logic clk = 0, rst_n, wr = 0, rd = 0, pin = 0, strt = 0, go = 0;
  logic rd_d = 0, busy, samp, flt, stim, sdo, sdo_oe, sclk, cs_n, done;
  logic [7:0] addr = 8'h00, ch_in, ch_ref;
  logic [15:0] wd = 16'h0000, rdata, spi_word = 16'h0000, host_word;
  logic [15:0] lfsr = 16'h0017, exp_q[$];
  logic [11:0] dac, target = 12'h000;
  logic [2:0] gpio;
  admc_aux_mux_t amux;
  admc_diag_cfg_t dcfg;
  int num_errors = 0, checks = 0;
  always #4 clk = ~clk;
  // Ideal comparator: the input is the target code.
  wire cmp = target >= dac;
  admc_top #(.CHANNELS(8), .ACQ_CYCLES(2)) dut (.I_CLOCK(clk),
    .I_RESET_N(rst_n), .I_REG_ADDR(addr), .I_REG_WDATA(wd),
    .I_REG_WRITE(wr), .I_REG_READ(rd), .O_REG_RDATA(rdata),
    .I_PIN_CTRL_MODE(pin), .I_AUX_CONVERT_START_PIN(strt), .O_GPIO(gpio),
    .I_SAR_CMP(cmp), .O_SAR_DAC(dac), .O_SAR_SAMPLE(samp),
    .O_SAR_BUSY(busy), .O_AUX_MUX(amux), .O_DIAG_CFG(dcfg),
    .O_DIAG_FLOAT(flt), .O_DIAG_STIM_280MV(stim),
    .O_CH_INPUT_FROM_DIAG(ch_in), .O_CH_REF_SUPPLY(ch_ref), .I_SCLK(sclk),
    .I_CS_N(cs_n), .I_SPI_REG_WORD(spi_word), .O_SDO(sdo),
    .O_SDO_OE(sdo_oe));
  admc_spi_host u_host (.i_go(go), .i_sdo(sdo), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_word(host_word), .o_done(done));
  // ====================
  // Tasks.
  function automatic logic [15:0] rnd(input logic [15:0] s);
    rnd = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : rnd
  task automatic check(input logic [15:0] seen, input logic [15:0] e);
    checks++;
    if (seen !== e)
    begin
      num_errors++;
      $display("ERROR t=%0t seen %h exp %h", $time, seen, e);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic timeout;
    num_errors++;
    close_out();
  endtask : timeout
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg
  task automatic frame(input logic [15:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    check({15'h0000, sdo_oe}, 16'h0001);
    for (n = 0; done !== 1'b1 && n < 400; n++)
      @(negedge clk);
    if (n == 400)
      timeout();
    check({15'h0000, sdo_oe}, 16'h0000);
  endtask : frame
  // Pulse the start pin w cycles; s says whether a conversion must follow.
  task automatic conv(input logic [11:0] t, input int w, input logic s);
    int n;
    @(posedge clk);
    target <= t;
    strt <= 1'b1;
    repeat (w) @(posedge clk);
    strt <= 1'b0;
    for (n = 0; busy !== 1'b1 && n < 10; n++)
      @(negedge clk);
    check({15'h0000, busy}, {15'h0000, s});
    for (n = 0; busy !== 1'b0 && n < 64; n++)
      @(negedge clk);
    if (n == 64)
      timeout();
    // Starts are spaced wider than the 256 kHz limit.
    repeat (490) @(posedge clk);
  endtask : conv
  // ====================
  // Result monitor: each result takes the oldest note.
  always @(posedge clk)
  begin
    rd_d <= rd;
    if (rd_d)
      check(rdata, exp_q.pop_front());
  end
  always @(posedge done)
    check(host_word, exp_q.pop_front());
  // ====================
  // Main sequence.
  initial
  begin
    // Unknown to low is an edge, so the stopped link domain resets too.
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rreg(ADMC_OFS_CTRL, 16'h0004);
    rreg(8'h1F, 16'h0000);
    lfsr = rnd(lfsr);
    spi_word <= lfsr;
    frame(lfsr);
    for (int c = 0; c < 23; c++)
    begin
      wreg(ADMC_OFS_AUX_MUX, 16'(c));
      rreg(ADMC_OFS_AUX_MUX, (c < 22) ? 16'(c) : 16'h0015);
      check({11'h000, amux.sel}, (c < 22) ? 16'(c) : 16'h0015);
    end
    for (int c = 0; c < 10; c++)
    begin
      wreg(ADMC_OFS_DIAG, 16'(c % 4 * 16 + c));
      rreg(ADMC_OFS_DIAG, 16'(c % 4 * 16 + c));
      check({14'h0000, dcfg.ref_sel}, 16'(c % 4));
    end
    wreg(ADMC_OFS_DIAG, 16'h000F);
    @(negedge clk);
    check({12'h000, dcfg.code}, 16'h0009);
    check({14'h0000, dcfg.ref_sel}, 16'h0000);
    for (int k = 0; k < 3; k++)
    begin
      lfsr = rnd(lfsr);
      wreg(ADMC_OFS_CH_DIAG_EN, {8'h00, lfsr[7:0]});
      wreg(ADMC_OFS_CH_REF_MON, {8'h00, lfsr[15:8]});
      wreg(ADMC_OFS_GPIO, lfsr);
      @(negedge clk);
      check({8'h00, ch_in}, {8'h00, lfsr[7:0] | lfsr[15:8]});
      check({8'h00, ch_ref}, {8'h00, lfsr[15:8]});
      check({13'h0000, gpio}, {13'h0000, lfsr[2:0]});
    end
    // Readout on with direct start; a dummy frame lets the select cross.
    wreg(ADMC_OFS_CTRL, 16'h0007);
    spi_word <= 16'h0000;
    frame(16'h0000);
    for (int k = 0; k < 2; k++)
    begin
      lfsr = rnd(lfsr);
      conv(lfsr[11:0], 1, 1'b1);
      frame({4'h0, lfsr[11:0]});
    end
    lfsr = rnd(lfsr);
    conv(lfsr[11:0], 1, 1'b1);
    rreg(ADMC_OFS_AUX_RESULT, {4'h0, lfsr[11:0]});
    // Filtered start: a short pulse is dropped, a long one starts.
    wreg(ADMC_OFS_CTRL, 16'h0005);
    conv(12'h000, 1, 1'b0);
    lfsr = rnd(lfsr);
    conv(lfsr[11:0], 3, 1'b1);
    rreg(ADMC_OFS_AUX_RESULT, {4'h0, lfsr[11:0]});
    // Pin control mode parks the general outputs; the one-cycle start after it is dropped by the filter too.
    @(posedge clk);
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({13'h0000, gpio}, 16'h0000);
    rreg(ADMC_OFS_STATUS, 16'h0004);
    conv(12'h0AA, 1, 1'b0);
    close_out();
  end
endmodule : aux_adc_diag_mux_control_test
